/* File: sar_pkg.sv */
// Shared constants and types for the serial converter readout
package sar_pkg;
   localparam int RESULT_W = 16;
   localparam logic [4:0] MSB_IDX = 5'h0f;
   localparam logic [4:0] LSB_IDX = 5'h00;
   // Falling edges after select falls before the null bit is driven
   localparam logic [2:0] SAMPLE_EDGES = 3'h5;
   localparam logic [RESULT_W-1:0] CODE_ZERO = 16'h0000;
   localparam logic [RESULT_W-1:0] CODE_MID = 16'h8000;
   localparam logic [RESULT_W-1:0] CODE_FULL = 16'hffff;
   // Code step is the reference divided by this many steps
   localparam int CODE_STEPS = 65536;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_NULL,
      ST_MSB_FIRST,
      ST_LSB_FIRST,
      ST_DONE
   } seq_state_t;

   typedef struct packed {
      logic dat_o;
      logic dat_oe;
   } dout_pin_t;

   typedef struct packed {
      logic sel_n;
      logic sclk;
   } link_in_t;
endpackage : sar_pkg

/* File: pin_sync.sv */
// Three-stage synchroniser for the link input pins
`timescale 1ns/100ps
module pin_sync
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire sar_pkg::link_in_t pin_i,
   output sar_pkg::link_in_t stable_o
);
   sar_pkg::link_in_t s1_q;
   sar_pkg::link_in_t s2_q;
   sar_pkg::link_in_t s3_q;
   sar_pkg::link_in_t stable_q;
   // Select idles high so the sequencer wakes in idle
   localparam sar_pkg::link_in_t IDLE_PINS = 2'h2;

   // A change counts only once stages two and three agree
   wire sar_pkg::link_in_t agree_d = (s2_q ~^ s3_q);
   sar_pkg::link_in_t stable_d;
   assign stable_d.sel_n = agree_d.sel_n ? s3_q.sel_n : stable_q.sel_n;
   assign stable_d.sclk = agree_d.sclk ? s3_q.sclk : stable_q.sclk;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_q <= IDLE_PINS;
         s2_q <= IDLE_PINS;
         s3_q <= IDLE_PINS;
         stable_q <= IDLE_PINS;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         stable_q <= stable_d;
      end
   end

   assign stable_o = stable_q;
endmodule : pin_sync

/* File: sar_readout.sv */
// Serial conversion sequencer and readout of the 16-bit converter
// Operation
// - Output bits change on serial_clock falling edges
// - Select falling starts conversion and transfer
// - First five clock periods sample, output tri-stated
// - Fifth falling edge drives one low null bit
// - Next sixteen periods shift result MSB first
// - After result_lsb, result repeats LSB first
// - After result_msb repeated, tri-state, ignore clocks
// - New conversion needs select high then low
// - Result coded as unsigned straight binary
// - Ideal codes FFFF, 8000, 7FFF, 0000
// - Code step is reference over 65536
// - Bits belong to current conversion, no pipeline
// - Select high powers down everything, incl logic
// - Raising select aborts cycle, delivered bits valid
`timescale 1ns/100ps
module sar_readout
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic sel_n,
   input wire logic serial_clock,
   input wire logic [15:0] sample_code,
   output logic dout_o,
   output logic dout_oe,
   output logic analog_pd,
   output logic digital_pd
);
   sar_pkg::link_in_t pins_raw;
   sar_pkg::link_in_t pins;
   sar_pkg::seq_state_t state_q;
   sar_pkg::seq_state_t state_d;
   logic sclk_prev_q;
   logic [2:0] edge_cnt_q;
   logic [2:0] edge_cnt_d;
   logic [4:0] bit_idx_q;
   logic [4:0] bit_idx_d;
   logic [sar_pkg::RESULT_W-1:0] result_q;
   logic [sar_pkg::RESULT_W-1:0] result_d;
   sar_pkg::dout_pin_t pin_q;
   sar_pkg::dout_pin_t pin_d;

   assign pins_raw.sel_n = sel_n;
   assign pins_raw.sclk = serial_clock;

   pin_sync u_sync
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pin_i(pins_raw),
      .stable_o(pins)
   );

   wire sclk_fall = sclk_prev_q & ~pins.sclk;
   wire sel_high = pins.sel_n;
   // Straight binary: the code is passed through untouched
   wire [sar_pkg::RESULT_W-1:0] code_in = sample_code;

   always_comb
   begin
      state_d = state_q;
      edge_cnt_d = edge_cnt_q;
      bit_idx_d = bit_idx_q;
      result_d = result_q;
      pin_d = pin_q;
      if (sel_high)
      begin
         // Any point of the cycle: abort and float the line
         state_d = sar_pkg::ST_IDLE;
         pin_d.dat_oe = 1'b0;
         pin_d.dat_o = 1'b0;
      end
      else
      begin
         case (state_q)
            sar_pkg::ST_IDLE:
            begin
               // Only a fresh low after high gets here
               state_d = sar_pkg::ST_SAMPLE;
               edge_cnt_d = '0;
               pin_d.dat_oe = 1'b0;
            end
            sar_pkg::ST_SAMPLE:
            begin
               if (sclk_fall)
               begin
                  edge_cnt_d = edge_cnt_q + 3'h1;
                  if (edge_cnt_q + 3'h1 == sar_pkg::SAMPLE_EDGES)
                  begin
                     // Hold the current sample for this cycle
                     result_d = code_in;
                     state_d = sar_pkg::ST_NULL;
                     pin_d.dat_oe = 1'b1;
                     pin_d.dat_o = 1'b0;
                  end
               end
            end
            sar_pkg::ST_NULL:
            begin
               if (sclk_fall)
               begin
                  state_d = sar_pkg::ST_MSB_FIRST;
                  bit_idx_d = sar_pkg::MSB_IDX;
                  pin_d.dat_o = result_q[sar_pkg::MSB_IDX[3:0]];
               end
            end
            sar_pkg::ST_MSB_FIRST:
            begin
               if (sclk_fall)
               begin
                  if (bit_idx_q == sar_pkg::LSB_IDX)
                  begin
                     // result_lsb is sent twice back to back
                     state_d = sar_pkg::ST_LSB_FIRST;
                     pin_d.dat_o = result_q[sar_pkg::LSB_IDX[3:0]];
                  end
                  else
                  begin
                     bit_idx_d = bit_idx_q - 5'h01;
                     pin_d.dat_o = result_q[bit_idx_d[3:0]];
                  end
               end
            end
            sar_pkg::ST_LSB_FIRST:
            begin
               if (sclk_fall)
               begin
                  if (bit_idx_q == sar_pkg::MSB_IDX)
                  begin
                     state_d = sar_pkg::ST_DONE;
                     pin_d.dat_oe = 1'b0;
                     pin_d.dat_o = 1'b0;
                  end
                  else
                  begin
                     bit_idx_d = bit_idx_q + 5'h01;
                     pin_d.dat_o = result_q[bit_idx_d[3:0]];
                  end
               end
            end
            default:
            begin
               // Further clocks have no effect until select rises
               pin_d.dat_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= sar_pkg::ST_IDLE;
         sclk_prev_q <= 1'b0;
         edge_cnt_q <= '0;
         bit_idx_q <= '0;
         result_q <= sar_pkg::CODE_ZERO;
         pin_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         sclk_prev_q <= pins.sclk;
         edge_cnt_q <= edge_cnt_d;
         bit_idx_q <= bit_idx_d;
         result_q <= result_d;
         pin_q <= pin_d;
      end
   end

   assign dout_o = pin_q.dat_o;
   assign dout_oe = pin_q.dat_oe;
   // Power hints; the analog side sleeps once shifting ends
   assign digital_pd = sel_high;
   assign analog_pd = sel_high | (state_q == sar_pkg::ST_DONE);

   a_float_when_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(sel_high) |=> !dout_oe)
      else $error("output driven after select rose");
   a_sample_tristate: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_SAMPLE) |-> !dout_oe)
      else $error("output driven during sampling");
   a_null_is_low: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_NULL) |-> dout_oe && !dout_o)
      else $error("null bit not low");
   a_change_on_fall: assert property (@(posedge ref_clk) disable iff (!rstn)
      (!sel_high && $changed(dout_o) && !$past(sel_high)) |-> $past(sclk_fall))
      else $error("data changed without falling edge");
   a_done_floats: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_DONE) |-> !dout_oe && analog_pd)
      else $error("output driven after reversed msb");
   a_msb_first_bit: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_NULL && sclk_fall && !sel_high) |=> dout_o == result_q[15])
      else $error("first data bit not msb");
   a_lsb_twice: assert property (@(posedge ref_clk) disable iff (!rstn)
      ($rose(state_q == sar_pkg::ST_LSB_FIRST)) |-> dout_o == result_q[0])
      else $error("reversed sequence not lsb first");
   a_idle_after_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
      sel_high |=> state_q == sar_pkg::ST_IDLE)
      else $error("sequencer not idle after select high");
   a_digital_pd: assert property (@(posedge ref_clk) disable iff (!rstn)
      digital_pd == sel_high)
      else $error("power down does not follow select");
   a_done_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_DONE && !sel_high) |=> state_q == sar_pkg::ST_DONE)
      else $error("sequencer left done without select high");
   // The last forward bit must stay on the line for a second period
   a_lsb_repeat: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_MSB_FIRST && bit_idx_q == sar_pkg::LSB_IDX
         && sclk_fall && !sel_high) |=> dout_oe && dout_o == $past(dout_o))
      else $error("lsb not repeated");
   a_capture_now: assert property (@(posedge ref_clk) disable iff (!rstn)
      (state_q == sar_pkg::ST_SAMPLE && sclk_fall && !sel_high
         && edge_cnt_q == sar_pkg::SAMPLE_EDGES - 3'h1)
      |=> state_q == sar_pkg::ST_NULL && result_q == $past(code_in))
      else $error("result not taken at end of sampling");

   c_full_frame: cover property (@(posedge ref_clk) disable iff (!rstn)
      state_q == sar_pkg::ST_DONE);
   c_short_cycle: cover property (@(posedge ref_clk) disable iff (!rstn)
      state_q == sar_pkg::ST_MSB_FIRST ##1 sel_high);
   c_reverse: cover property (@(posedge ref_clk) disable iff (!rstn)
      $rose(state_q == sar_pkg::ST_LSB_FIRST));
   c_abort_sample: cover property (@(posedge ref_clk) disable iff (!rstn)
      state_q == sar_pkg::ST_SAMPLE ##1 sel_high);
endmodule : sar_readout

/* File: host_model.sv */
// Host-side serial master model that frames conversions and captures data
`timescale 1ns/100ps
module host_model
(
   input wire logic ref_clk,
   output logic sel_n,
   output logic serial_clock,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic analog_pd,
   input wire logic digital_pd,
   output logic [3:0] cap_val,
   output logic cap_stb
);
   initial
   begin
      sel_n = 1'b1;
      serial_clock = 1'b0;
      cap_val = 4'h0;
      cap_stb = 1'b0;
   end

   // Sample just after a falling edge: the block needs several clocks to answer,
   // so the line still holds the bit launched by the previous falling edge
   task automatic capture();
      @(negedge ref_clk);
      cap_val = {digital_pd, analog_pd, dout_oe, dout_oe & dout_o};
      cap_stb = 1'b1;
      #10 cap_stb = 1'b0;
   endtask : capture

   // Pins move on rising block clock edges; one link period is eight block clocks
   // Clock stands low outside frames; n falling edges are sent, then select rises
   task automatic frame(input int n);
      @(posedge ref_clk);
      sel_n <= 1'b0;
      repeat (8) @(posedge ref_clk);
      repeat (n)
      begin
         serial_clock <= 1'b1;
         repeat (4) @(posedge ref_clk);
         serial_clock <= 1'b0;
         capture();
         repeat (4) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      capture();
      @(posedge ref_clk);
      sel_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      capture();
      repeat (5) @(posedge ref_clk);
   endtask : frame
endmodule : host_model

/* File: sar_readout_tb_top.sv */
// Self-checking bench for the serial converter readout
`timescale 1ns/100ps
module sar_readout_tb_top;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] sample_code = 16'h0000;
   logic sel_n, serial_clock, dout_o, dout_oe, analog_pd, digital_pd, cap_stb;
   logic [3:0] cap_val;
   logic [3:0] exp_q[$];
   logic [31:0] seed = 32'h0e8f;
   int error_cnt = 0;
   int n_tests = 0;

   always #20 ref_clk = ~ref_clk;

   sar_readout DUT (.ref_clk(ref_clk), .rstn(rstn), .sel_n(sel_n),
      .serial_clock(serial_clock), .sample_code(sample_code), .dout_o(dout_o),
      .dout_oe(dout_oe), .analog_pd(analog_pd), .digital_pd(digital_pd));

   host_model HOST (.ref_clk(ref_clk), .sel_n(sel_n), .serial_clock(serial_clock),
      .dout_o(dout_o), .dout_oe(dout_oe), .analog_pd(analog_pd), .digital_pd(digital_pd),
      .cap_val(cap_val), .cap_stb(cap_stb));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   // Expected {digital_pd, analog_pd, dout_oe, data} once falling edge k has landed
   function automatic logic [3:0] exp_at(input logic [15:0] c, input int k);
      if (k < 5)
         return 4'h0;
      if (k == 5)
         return 4'h2;
      if (k <= 21)
         return {3'h1, c[21-k]};
      if (k <= 37)
         return {3'h1, c[k-22]};
      return 4'h4;
   endfunction : exp_at

   task automatic check(input logic [3:0] seen, input logic [3:0] want);
      n_tests++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic report_and_stop();
      if (error_cnt == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // The code is held through the frame, so the fifth edge sees this frame's sample
   task automatic run(input logic [15:0] c, input int n);
      @(posedge ref_clk) sample_code <= c;
      for (int k = 0; k <= n; k++)
         exp_q.push_back(exp_at(c, k));
      exp_q.push_back(4'hc);
      HOST.frame(n);
   endtask : run

   always @(posedge cap_stb)
   begin
      check(cap_val, (exp_q.size() > 0) ? exp_q.pop_front() : 4'hf);
   end

   initial
   begin : main
      logic [15:0] codes [4];
      codes = '{sar_pkg::CODE_FULL, sar_pkg::CODE_MID, 16'h7fff, sar_pkg::CODE_ZERO};
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      // Extra clocks past the reversed word must be ignored
      foreach (codes[i])
         run(codes[i], 40);
      for (int i = 0; i < 6; i++)
      begin
         seed = xorshift(seed);
         run(seed[15:0], (i % 2) ? 38 : 12 + 3 * i);
      end
      run(16'ha5c3, 3);
      run(16'h5a3c, 40);
      report_and_stop();
   end

   initial
   begin
      #1000000;
      error_cnt++;
      report_and_stop();
   end
endmodule : sar_readout_tb_top
